// ==== hdl/ebc_pkg.sv ====
// Purpose: constants for the external bus mode and port configuration registers
// Assumes: 8-bit internal register bus, byte offsets within the module window
// Notes: mode codes follow the three mode select bits
//
// How it works
// [RQ1] mode bits decode to eight modes, 110 being special peripheral
// [RQ2] emulation, normal expanded and peripheral modes ignore all mode writes
// [RQ3] special single chip and test take any mode write except to 110; test mode unmaps the register, so only special single chip does
// [RQ4] normal single chip: top bit fixed, lower two writable once, never 110
// [RQ5] leaving special for normal single chip leaves one write, else none
// [RQ6] secure state blocks every mode write
// [RQ7] pull register: bit 7 port k, 4 port e, 1 port b, 0 port a
// [RQ8] pulls act only on pins that are inputs
// [RQ9] port e pull enable covers pins 7,4:0; pins 5,6 pull only in reset
// [RQ10] drive register: same bit layout, one selects reduced drive
// [RQ11] reduced drive applies whatever function owns the pin
// [RQ12] expanded and peripheral modes remove the registers, accesses go external
// [RQ13] pull and drive registers read and write anytime while mapped
// [RQ14] stretch bit clear: e clock free; set: high on stretch, low when hidden
// [RQ15] stretch bit writes once in normal and emulation, anytime in special; the register maps only in single chip modes, never in emulation
// [RQ16] stretch bit has no effect in single chip modes
// [RQ17] accepted mode write takes effect one cycle after the write
// [RQ18] unimplemented bits read zero and ignore writes
// [RQ19] write-once tracking clears only at chip reset
package ebc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0b;
   localparam logic [ADDR_W-1:0] OFS_PULL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h0d;
   localparam logic [ADDR_W-1:0] OFS_STRETCH = 8'h0e;

   localparam int MODE_LSB = 5;
   localparam int BIT_PORT_K = 7;
   localparam int BIT_PORT_E = 4;
   localparam int BIT_PORT_B = 1;
   localparam int BIT_PORT_A = 0;
   localparam int BIT_ECLK_STRETCH_EN = 0;

   localparam logic [DATA_W-1:0] PORT_MASK = 8'h93;
   localparam logic [DATA_W-1:0] PULL_RST = 8'h00;
   localparam logic [DATA_W-1:0] DRIVE_RST = 8'h00;
   localparam logic [0:0] ECLK_STRETCH_EN_RST = 1'h1;
   localparam logic [7:0] PE_RESET_PULL = 8'h60;
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   localparam logic [2:0] MD_SPC_SINGLE = 3'h0;
   localparam logic [2:0] MD_EMU_NARROW = 3'h1;
   localparam logic [2:0] MD_SPC_TEST = 3'h2;
   localparam logic [2:0] MD_EMU_WIDE = 3'h3;
   localparam logic [2:0] MD_NRM_SINGLE = 3'h4;
   localparam logic [2:0] MD_NRM_NARROW = 3'h5;
   localparam logic [2:0] MD_SPC_PERIPH = 3'h6;
   localparam logic [2:0] MD_NRM_WIDE = 3'h7;
endpackage

// ==== hdl/ebc_pad_ctl.sv ====
// Purpose: per-pin pull and reduced drive controls for one port
// Assumes: dir_i one means the pin is driven as output
// Notes: outputs registered; RESET_PULL pins pull only in reset and for one cycle after release
`timescale 1ns/1ps
`default_nettype none
module ebc_pad_ctl #(
   parameter logic [7:0] PULL_MASK = 8'hff,
   parameter logic [7:0] RESET_PULL = 8'h00
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic pull_en_i,
   input wire logic low_drive_i,
   input wire logic [7:0] dir_i,
   output logic [7:0] pull_on_o,
   output logic [7:0] low_drv_o
);
   logic in_reset_ff;

   // cleared one edge after release so reset-only pulls cover the reset itself
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_reset_ff <= 1'b1;
      end else if (ce_i) begin
         in_reset_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pull_on_o <= RESET_PULL;
      end else if (ce_i) begin
         pull_on_o <= ({8{pull_en_i}} & PULL_MASK & ~dir_i) // [RQ8] [RQ9]
            | ({8{in_reset_ff}} & RESET_PULL & ~dir_i); // [RQ9]
      end
   end

   // outputs only, but independent of what drives the pin
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         low_drv_o <= 8'h00;
      end else if (ce_i) begin
         low_drv_o <= {8{low_drive_i}} & dir_i; // [RQ11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   inputs_no_pull_a: // [RQ8]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      ce_i |=> ((pull_on_o & $past(dir_i)) == 8'h00))
      else $error("pull active on an output pin");
   drive_follow_a: // [RQ11]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && low_drive_i) |=> (low_drv_o == $past(dir_i)))
      else $error("reduced drive missing on an output pin");
endmodule // ebc_pad_ctl
`default_nettype wire

// ==== hdl/ebc_cfg_regs.sv ====
// Purpose: mode select, pull, drive and e clock stretch registers of the bus block
// Assumes: one-cycle register accesses; secure_i and access status from same clock
// Notes: strap pins synchronised and caught on the third edge after reset release
`timescale 1ns/1ps
`default_nettype none
module ebc_cfg_regs
   import ebc_pkg::*;
#(
   parameter logic [DATA_W-1:0] PULL_RESET = PULL_RST,
   parameter logic [DATA_W-1:0] DRIVE_RESET = DRIVE_RST
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic [2:0] mode_strap_i,
   input wire logic secure_i,
   input wire logic reg_sel_i,
   input wire logic reg_wr_i,
   input wire logic [ebc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [ebc_pkg::DATA_W-1:0] reg_wdata_i,
   output logic [ebc_pkg::DATA_W-1:0] reg_rdata_o,
   output logic reg_hit_o,
   output logic ext_echo_o,
   input wire logic ext_stretch_i,
   input wire logic int_hidden_i,
   input wire logic [7:0] dir_a_i,
   input wire logic [7:0] dir_b_i,
   input wire logic [7:0] dir_e_i,
   input wire logic [7:0] dir_k_i,
   output logic [7:0] pull_a_o,
   output logic [7:0] pull_b_o,
   output logic [7:0] pull_e_o,
   output logic [7:0] pull_k_o,
   output logic [7:0] low_drv_a_o,
   output logic [7:0] low_drv_b_o,
   output logic [7:0] low_drv_e_o,
   output logic [7:0] low_drv_k_o,
   output logic [2:0] mode_o,
   output logic single_chip_o,
   output logic eclk_o
);
   logic [2:0] strap_s1_ff;
   logic [2:0] strap_s2_ff;
   logic [1:0] strap_cnt_ff;
   logic strap_done_ff;
   logic [2:0] mode_ff;
   logic [2:0] mode_pend_ff;
   logic mode_pend_vld_ff;
   logic mode_once_ff;
   logic [DATA_W-1:0] pull_ff;
   logic [DATA_W-1:0] drive_ff;
   logic eclk_stretch_en_ff;
   logic eclk_stretch_en_used_ff;
   logic eclk_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [2:0] nxt_mode;
   logic mode_acc;
   logic mapped;
   logic our_addr;
   logic wr_ok;
   logic eclk_stretch_en_acc;
   logic eclk_stretch_en_eff;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode helpers
   function automatic logic is_special(input logic [2:0] m);
      return (m == MD_SPC_SINGLE) || (m == MD_SPC_TEST) || (m == MD_SPC_PERIPH);
   endfunction

   function automatic logic is_single(input logic [2:0] m);
      return (m == MD_SPC_SINGLE) || (m == MD_NRM_SINGLE);
   endfunction

   // expanded, emulation and peripheral modes drop the registers out of the map
   function automatic logic is_unmapped(input logic [2:0] m);
      return !is_single(m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // strap pins: two-stage sync, then caught once the sync has settled
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_s1_ff <= 3'h0;
         strap_s2_ff <= 3'h0;
      end else if (ce_i) begin
         strap_s1_ff <= mode_strap_i;
         strap_s2_ff <= strap_s1_ff;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_cnt_ff <= 2'h0;
         strap_done_ff <= 1'b0;
      end else if (ce_i && !strap_done_ff) begin
         if (strap_cnt_ff == STRAP_WAIT) begin
            strap_done_ff <= 1'b1;
         end else begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus decode
   assign our_addr = (reg_addr_i == OFS_MODE) || (reg_addr_i == OFS_PULL)
      || (reg_addr_i == OFS_DRIVE) || (reg_addr_i == OFS_STRETCH);
   assign mapped = strap_done_ff && !is_unmapped(mode_ff);
   assign reg_hit_o = reg_sel_i && our_addr && mapped;
   assign ext_echo_o = reg_sel_i && our_addr && strap_done_ff && !mapped; // [RQ12]
   assign wr_ok = reg_hit_o && reg_wr_i;

   ////////////////////////////////////////////////////////////////////////////
   // mode write qualification
   always_comb begin
      nxt_mode = reg_wdata_i[MODE_LSB +: 3];
      mode_acc = 1'b0;
      if (wr_ok && (reg_addr_i == OFS_MODE) && !secure_i) begin // [RQ6]
         case (mode_ff)
            MD_SPC_SINGLE, MD_SPC_TEST: begin
               mode_acc = (nxt_mode != MD_SPC_PERIPH); // [RQ3]
            end
            MD_NRM_SINGLE: begin
               nxt_mode = {1'b1, reg_wdata_i[MODE_LSB +: 2]}; // [RQ4]
               mode_acc = mode_once_ff && (nxt_mode != MD_SPC_PERIPH); // [RQ4]
            end
            default: begin
               mode_acc = 1'b0; // [RQ2]
            end
         endcase
      end
   end

   // accepted value waits in a holding stage so the change lands a cycle late
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_pend_ff <= MD_SPC_SINGLE;
         mode_pend_vld_ff <= 1'b0;
      end else if (ce_i) begin
         mode_pend_ff <= nxt_mode;
         mode_pend_vld_ff <= mode_acc; // [RQ17]
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_ff <= MD_SPC_SINGLE;
      end else if (ce_i) begin
         if (!strap_done_ff && (strap_cnt_ff == STRAP_WAIT)) begin
            mode_ff <= strap_s2_ff;
         end else if (mode_pend_vld_ff) begin
            mode_ff <= mode_pend_ff; // [RQ17]
         end
      end
   end

   // one write left whenever normal single chip is entered, by strap or from special
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_once_ff <= 1'b1; // [RQ19]
      end else if (ce_i && mode_acc) begin
         mode_once_ff <= is_special(mode_ff) && (nxt_mode == MD_NRM_SINGLE); // [RQ5]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pull and drive registers, unimplemented bits held at zero
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pull_ff <= PULL_RESET & PORT_MASK;
      end else if (ce_i && wr_ok && (reg_addr_i == OFS_PULL)) begin
         pull_ff <= reg_wdata_i & PORT_MASK; // [RQ7] [RQ13] [RQ18]
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drive_ff <= DRIVE_RESET & PORT_MASK;
      end else if (ce_i && wr_ok && (reg_addr_i == OFS_DRIVE)) begin
         drive_ff <= reg_wdata_i & PORT_MASK; // [RQ10] [RQ13] [RQ18]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stretch control
   assign eclk_stretch_en_acc = wr_ok && (reg_addr_i == OFS_STRETCH)
      && (is_special(mode_ff) || !eclk_stretch_en_used_ff); // [RQ15]

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         eclk_stretch_en_ff <= ECLK_STRETCH_EN_RST;
         eclk_stretch_en_used_ff <= 1'b0; // [RQ19]
      end else if (ce_i && eclk_stretch_en_acc) begin
         eclk_stretch_en_ff <= reg_wdata_i[BIT_ECLK_STRETCH_EN];
         eclk_stretch_en_used_ff <= 1'b1;
      end
   end

   assign eclk_stretch_en_eff = eclk_stretch_en_ff && !is_single(mode_ff); // [RQ16]

   // e clock: free toggle unless stretching is in force
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         eclk_ff <= 1'b0;
      end else if (ce_i) begin
         if (eclk_stretch_en_eff && ext_stretch_i) begin
            eclk_ff <= 1'b1; // [RQ14]
         end else if (eclk_stretch_en_eff && int_hidden_i) begin
            eclk_ff <= 1'b0; // [RQ14]
         end else begin
            eclk_ff <= !eclk_ff; // [RQ14]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data registered; other mode register bits belong elsewhere and read zero
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= 8'h00;
      end else if (ce_i) begin
         rdata_ff <= 8'h00;
         if (reg_hit_o) begin
            case (reg_addr_i)
               OFS_MODE: rdata_ff <= {mode_ff, 5'h00};
               OFS_PULL: rdata_ff <= pull_ff;
               OFS_DRIVE: rdata_ff <= drive_ff;
               OFS_STRETCH: rdata_ff <= {7'h00, eclk_stretch_en_ff}; // [RQ18]
               default: rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign mode_o = mode_ff; // [RQ1]
   assign single_chip_o = is_single(mode_ff); // [RQ1]
   assign eclk_o = eclk_ff;

   ////////////////////////////////////////////////////////////////////////////
   // pad controls, one per port
   ebc_pad_ctl #(.PULL_MASK(8'hff), .RESET_PULL(8'h00)) u_pad_a (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .pull_en_i(pull_ff[BIT_PORT_A]), .low_drive_i(drive_ff[BIT_PORT_A]),
      .dir_i(dir_a_i), .pull_on_o(pull_a_o), .low_drv_o(low_drv_a_o));
   ebc_pad_ctl #(.PULL_MASK(8'hff), .RESET_PULL(8'h00)) u_pad_b (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .pull_en_i(pull_ff[BIT_PORT_B]), .low_drive_i(drive_ff[BIT_PORT_B]),
      .dir_i(dir_b_i), .pull_on_o(pull_b_o), .low_drv_o(low_drv_b_o));
   ebc_pad_ctl #(.PULL_MASK(~PE_RESET_PULL), .RESET_PULL(PE_RESET_PULL)) u_pad_e (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .pull_en_i(pull_ff[BIT_PORT_E]), .low_drive_i(drive_ff[BIT_PORT_E]),
      .dir_i(dir_e_i), .pull_on_o(pull_e_o), .low_drv_o(low_drv_e_o)); // [RQ9]
   ebc_pad_ctl #(.PULL_MASK(8'hff), .RESET_PULL(8'h00)) u_pad_k (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .pull_en_i(pull_ff[BIT_PORT_K]), .low_drive_i(drive_ff[BIT_PORT_K]),
      .dir_i(dir_k_i), .pull_on_o(pull_k_o), .low_drv_o(low_drv_k_o));

   ////////////////////////////////////////////////////////////////////////////
   mode_decode_a: // [RQ1]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      single_chip_o == ((mode_o == 3'h0) || (mode_o == 3'h4)))
      else $error("single chip decode wrong");
   locked_mode_a: // [RQ2]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (strap_done_ff && !is_special(mode_ff) && (mode_ff != MD_NRM_SINGLE)
      && !mode_pend_vld_ff) |=> $stable(mode_ff))
      else $error("locked mode changed");
   no_periph_a: // [RQ3]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      mode_acc |-> (nxt_mode != 3'h6))
      else $error("write to peripheral mode accepted");
   top_bit_a: // [RQ4]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (mode_acc && (mode_ff == 3'h4)) |-> nxt_mode[2])
      else $error("top mode bit cleared from normal single chip");
   once_spent_a: // [RQ5]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && mode_acc && (mode_ff == 3'h4)) |=> !mode_once_ff)
      else $error("second write left in normal single chip");
   secure_block_a: // [RQ6]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      secure_i |-> !mode_acc)
      else $error("mode write accepted while secure");
   late_apply_a: // [RQ17]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && mode_acc) ##1 ce_i |-> ($stable(mode_ff) ##1 (mode_ff == $past(nxt_mode, 2))))
      else $error("mode write timing wrong");
   unmapped_a: // [RQ12]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (strap_done_ff && !single_chip_o) |-> !reg_hit_o)
      else $error("register mapped in expanded mode");
   eclk_stretch_en_once_a: // [RQ15]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (eclk_stretch_en_used_ff && !is_special(mode_ff)) |=> $stable(eclk_stretch_en_ff))
      else $error("stretch bit written twice");
   eclk_free_a: // [RQ14]
   assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (ce_i && !eclk_stretch_en_eff) |=> (eclk_o != $past(eclk_o)))
      else $error("e clock not free running");
endmodule // ebc_cfg_regs
`default_nettype wire

// ==== tb/ebc_far_side.sv ====
// Purpose: far side of the bus block: strap pins, bus activity, pad directions
// Assumes: all changes made just after a rising clock edge
// Notes: counts accesses echoed onto the external bus
`timescale 1ns/1ps
`default_nettype none
module ebc_far_side (
   input wire logic mclk_i,
   input wire logic ext_echo_i,
   output logic [2:0] mode_strap_o,
   output logic ext_stretch_o,
   output logic int_hidden_o,
   output logic [7:0] dir_a_o,
   output logic [7:0] dir_b_o,
   output logic [7:0] dir_e_o,
   output logic [7:0] dir_k_o
);
   int echo_cnt;
   initial begin
      echo_cnt = 0;
      mode_strap_o = 3'h0;
      ext_stretch_o = 1'b0;
      int_hidden_o = 1'b0;
      {dir_a_o, dir_b_o, dir_e_o, dir_k_o} = 32'h0;
   end
   // straps held well before and after reset release
   task automatic set_strap(input logic [2:0] s);
      @(posedge mclk_i);
      mode_strap_o <= s;
   endtask
   task automatic set_bus(input logic st, input logic hid);
      @(posedge mclk_i);
      ext_stretch_o <= st;
      int_hidden_o <= hid;
   endtask
   task automatic set_dirs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] e,
                           input logic [7:0] k);
      @(posedge mclk_i);
      {dir_a_o, dir_b_o, dir_e_o, dir_k_o} <= {a, b, e, k};
   endtask
   // unmapped accesses land here, one per access cycle
   always @(posedge mclk_i) begin
      if (ext_echo_i) echo_cnt <= echo_cnt + 1;
   end
endmodule // ebc_far_side
`default_nettype wire

// ==== tb/tb_ext_bus_mode_port_config.sv ====
// Purpose: self-checking bench for the bus mode and port configuration registers
// Assumes: ce held high; far side model supplies straps, activity and directions
// Notes: integer model of mode, stretch, pull and drive state checked at every result
`timescale 1ns/1ps
`default_nettype none
module tb_ext_bus_mode_port_config;
   import ebc_pkg::*;
   logic mclk_i, rstn_i, sel, wr, secure, hit, echo, sc, eclk, ext_st, hid, hit_s, echo_s;
   logic [7:0] addr, wdata, rdata, rd_s, dir_a, dir_b, dir_e, dir_k;
   logic [7:0] pull_a, pull_b, pull_e, pull_k, low_a, low_b, low_e, low_k;
   logic [2:0] strap, mode;
   int err_count, n_tests, n_echo, seed, m_mode, m_once, m_str, m_sonce, m_pull, m_drv;

   ebc_far_side far_u (.mclk_i(mclk_i), .ext_echo_i(echo), .mode_strap_o(strap),
      .ext_stretch_o(ext_st), .int_hidden_o(hid), .dir_a_o(dir_a), .dir_b_o(dir_b),
      .dir_e_o(dir_e), .dir_k_o(dir_k));
   ebc_cfg_regs dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .mode_strap_i(strap),
      .secure_i(secure), .reg_sel_i(sel), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit), .ext_echo_o(echo),
      .ext_stretch_i(ext_st), .int_hidden_i(hid), .dir_a_i(dir_a), .dir_b_i(dir_b),
      .dir_e_i(dir_e), .dir_k_i(dir_k), .pull_a_o(pull_a), .pull_b_o(pull_b),
      .pull_e_o(pull_e), .pull_k_o(pull_k), .low_drv_a_o(low_a), .low_drv_b_o(low_b),
      .low_drv_e_o(low_e), .low_drv_k_o(low_k), .mode_o(mode), .single_chip_o(sc),
      .eclk_o(eclk));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input int exp, input string what);
      n_tests++;
      if (got !== 8'(exp)) begin
         err_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, 8'(exp));
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic logic mapped();
      return m_mode == 0 || m_mode == 4;
   endfunction
   function automatic int exp_rd(input int a);
      if (!mapped()) return 0;
      case (a)
         11: return m_mode << 5;
         12: return m_pull;
         13: return m_drv;
         14: return m_str;
         default: return 0;
      endcase
   endfunction
////////////////////////////////////////////////////////////////////////////////
   // one access cycle; request held until the taking edge
   task automatic acc(input logic w, input int a, input int d);
      logic m;
      m = mapped();
      @(posedge mclk_i);
      sel <= 1'b1;
      wr <= w;
      addr <= 8'(a);
      wdata <= 8'(d);
      @(negedge mclk_i);
      hit_s = hit;
      echo_s = echo;
      @(posedge mclk_i);
      sel <= 1'b0;
      #1 rd_s = rdata;
      if (a != 15) chk1(hit_s, m && a >= 11, "hit");
      chk1(echo_s, !m && a >= 11 && a <= 14, "echo");
      if (!m && a >= 11 && a <= 14) n_echo++;
   endtask
   task automatic rd_reg(input int a);
      int e;
      e = exp_rd(a);
      acc(1'b0, a, 0);
      chk8(rd_s, e, "read data");
   endtask
   task automatic wr_reg(input int a, input int d);
      int nv;
      nv = (d >> 5) & 7;
      // bus access first: the map seen by this access is the one before the write
      acc(1'b1, a, d);
      if (mapped()) begin
         if (a == 12) m_pull = d & 'h93;
         if (a == 13) m_drv = d & 'h93;
         if (a == 14 && (m_mode == 0 || m_sonce)) begin
            m_str = d & 1;
            m_sonce = m_sonce && m_mode == 0;
         end
         if (a == 11 && !secure && m_mode == 0 && nv != 6) begin
            m_mode = nv;
            m_once = nv == 4;
         end else if (a == 11 && !secure && m_mode == 4 && m_once && (4 | (nv & 3)) != 6) begin
            m_mode = 4 | (nv & 3);
            m_once = 0;
         end
      end
   endtask
   task automatic chk_mode();
      repeat (2) @(posedge mclk_i);
      #1 chk8({5'h0, mode}, m_mode, "mode");
      chk1(sc, mapped(), "single chip");
   endtask
   task automatic chk_pads();
      repeat (2) @(posedge mclk_i);
      #1 chk8(pull_a, m_pull[0] ? ~dir_a : 8'h00, "pull a");
      chk8(pull_b, m_pull[1] ? ~dir_b : 8'h00, "pull b");
      chk8(pull_e, m_pull[4] ? ~dir_e & 8'h9f : 8'h00, "pull e");
      chk8(pull_k, m_pull[7] ? ~dir_k : 8'h00, "pull k");
      chk8(low_a, m_drv[0] ? dir_a : 8'h00, "drive a");
      chk8(low_b, m_drv[1] ? dir_b : 8'h00, "drive b");
      chk8(low_e, m_drv[4] ? dir_e : 8'h00, "drive e");
      chk8(low_k, m_drv[7] ? dir_k : 8'h00, "drive k");
   endtask
   // kind 0 free running, 1 held high, 2 held low
   task automatic chk_eclk(input int kind);
      logic prev;
      @(posedge mclk_i);
      #1 prev = eclk;
      repeat (4) begin
         @(posedge mclk_i);
         #1 chk1(eclk, kind == 0 ? !prev : kind == 1, "eclk");
         prev = eclk;
      end
   endtask
   task automatic do_reset(input int s);
      @(posedge mclk_i);
      rstn_i <= 1'b0;
      far_u.set_strap(3'(s));
      far_u.set_dirs(8'h00, 8'h00, 8'h00, 8'h00);
      far_u.set_bus(1'b0, 1'b0);
      @(posedge mclk_i);
      #1 chk8(pull_e, 8'h60, "reset pull e");
      @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      {m_mode, m_once, m_str, m_sonce, m_pull, m_drv} = {s, int'(s == 4), 1, 1, 0, 0};
      chk_mode();
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   initial begin
      {err_count, n_tests, n_echo, seed} = {0, 0, 0, 26809};
      {rstn_i, sel, wr, secure, addr, wdata} = 0;
      for (int s = 0; s < 8; s++) begin
         do_reset(s);
         chk_pads();
         for (int a = 11; a <= 15; a++) rd_reg(a);
         wr_reg(11, 8'h80);
         chk_mode();
      end
      do_reset(0);
      repeat (12) begin
         far_u.set_dirs(8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
                        8'($random(seed)));
         wr_reg(12, $random(seed));
         wr_reg(13, $random(seed));
         wr_reg(15, $random(seed));
         for (int a = 12; a <= 15; a++) rd_reg(a);
         chk_pads();
      end
      @(posedge mclk_i);
      secure <= 1'b1;
      wr_reg(11, 8'h80);
      chk_mode();
      @(posedge mclk_i);
      secure <= 1'b0;
      wr_reg(11, 8'hc0);
      chk_mode();
      for (int i = 0; i < 3; i++) wr_reg(14, i & 1);
      rd_reg(14);
      wr_reg(11, 8'h80);
      chk_mode();
      wr_reg(11, 8'h00);
      chk_mode();
      wr_reg(11, 8'h20);
      chk_mode();
      do_reset(4);
      far_u.set_bus(1'b1, 1'b0);
      chk_eclk(0);
      wr_reg(14, 0);
      wr_reg(14, 1);
      rd_reg(14);
      wr_reg(11, 8'h20);
      chk_mode();
      chk_eclk(0);
      rd_reg(12);
      do_reset(5);
      far_u.set_bus(1'b1, 1'b0);
      chk_eclk(1);
      far_u.set_bus(1'b0, 1'b1);
      chk_eclk(2);
      far_u.set_bus(1'b0, 1'b0);
      chk_eclk(0);
      do_reset(0);
      wr_reg(11, 8'h40);
      chk_mode();
      rd_reg(14);
      chk8(8'(far_u.echo_cnt), n_echo, "echo count");
      final_report();
   end
endmodule // tb_ext_bus_mode_port_config
`default_nettype wire
